// File: src/ccgs_regs.svh
// register offsets, field positions and reset values of the cpu clock generator
// assumes inclusion by the top module only
`ifndef CCGS_REGS_SVH
`define CCGS_REGS_SVH

`define CCGS_OFF_CFG_LATCH   8'h00
`define CCGS_OFF_RST_CTRL    8'h04
`define CCGS_OFF_CMD         8'h08
`define CCGS_OFF_STATUS      8'h0C
`define CCGS_OFF_PERIOD      8'h10

`define CCGS_CLKMODE_MSB     7
`define CCGS_CLKMODE_LSB     5
`define CCGS_CMD_LOAD_BIT    0
`define CCGS_ST_PLL_EN_BIT   3
`define CCGS_ST_LOCKED_BIT   4

`define CCGS_CFG_LATCH_RST   8'hFF
`define CCGS_RST_CTRL_RST    16'h0000
`define CCGS_PERIOD_INIT     16'h0028

`define CCGS_CM_X4           3'h7
`define CCGS_CM_X3           3'h6
`define CCGS_CM_X2           3'h5
`define CCGS_CM_X5           3'h4
`define CCGS_CM_DIRECT       3'h3
`define CCGS_CM_X1P5         3'h2
`define CCGS_CM_PRESCALE     3'h1
`define CCGS_CM_X2P5         3'h0

`endif

// File: src/ccgs_pkg.sv
// types shared by the cpu clock generator
// assumes nothing beyond the register header
package ccgs_pkg;
    typedef enum logic [1:0] {
        CCGS_MODE_PLL,
        CCGS_MODE_DIRECT,
        CCGS_MODE_PRESCALE
    } ccgs_mode_t;
endpackage

// File: src/ccgs_top.sv
// cpu clock generator: derives the cpu clock from the oscillator input
// assumes osc_in and config port synchronous to core_clk, AXI4-Lite master on the bus
`timescale 1ns/1ps
`include "ccgs_regs.svh"

module ccgs_top
    import ccgs_pkg::*;
#(
    parameter int PW = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // oscillator and configuration pins
    input wire logic osc_in,
    input wire logic [7:0] config_port_upper_byte,
    input wire logic long_hw_reset,
    // generated clock
    output logic cpu_clk,
    output logic clock_half_period,
    output logic pll_enable,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // reset release through two flops
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ---------------- configuration latch ----------------
    logic [7:0] cfg_latch_q;
    logic [7:0] cfg_latch_d;
    logic [15:0] rst_ctrl_q;
    logic [15:0] rst_ctrl_d;
    logic boot_q;
    logic sw_load;
    logic [2:0] clock_mode_field;

    // hardware capture wins over a software load in the same cycle
    assign cfg_latch_d = (boot_q || long_hw_reset) ? config_port_upper_byte :
                         sw_load ? rst_ctrl_q[15:8] :
                         cfg_latch_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_latch_q <= `CCGS_CFG_LATCH_RST;
            rst_ctrl_q <= `CCGS_RST_CTRL_RST;
            boot_q <= 1'b1;
        end else begin
            cfg_latch_q <= cfg_latch_d;
            rst_ctrl_q <= rst_ctrl_d;
            boot_q <= 1'b0;
        end
    end

    assign clock_mode_field = cfg_latch_q[`CCGS_CLKMODE_MSB:`CCGS_CLKMODE_LSB];

    // ---------------- mode decode ----------------
    ccgs_mode_t mode;
    logic [3:0] f_twice;
    logic [2:0] resync_span;

    // factor kept doubled so 1.5 and 2.5 stay integer
    assign mode = (clock_mode_field == `CCGS_CM_DIRECT) ? CCGS_MODE_DIRECT :
                  (clock_mode_field == `CCGS_CM_PRESCALE) ? CCGS_MODE_PRESCALE :
                  CCGS_MODE_PLL;
    assign f_twice = (clock_mode_field == `CCGS_CM_X4) ? 4'h8 :
                     (clock_mode_field == `CCGS_CM_X3) ? 4'h6 :
                     (clock_mode_field == `CCGS_CM_X2) ? 4'h4 :
                     (clock_mode_field == `CCGS_CM_X5) ? 4'hA :
                     (clock_mode_field == `CCGS_CM_X1P5) ? 4'h3 :
                     (clock_mode_field == `CCGS_CM_X2P5) ? 4'h5 :
                     4'h2;
    // fractional factors resync on the next whole transition count
    assign resync_span = 3'((f_twice + 4'h1) >> 1);

    // ---------------- oscillator sampling ----------------
    logic osc_q;
    logic osc_rise;
    logic osc_edge;
    logic [PW-1:0] meas_cnt_q;
    logic [PW-1:0] period_q;
    logic [2:0] trans_cnt_q;
    logic resync;

    assign osc_rise = osc_in && !osc_q;
    assign osc_edge = osc_in != osc_q;
    assign resync = osc_edge && (trans_cnt_q == resync_span - 3'h1);

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_in;
        end
    end

    // counter restarts at one on a rise, so before the next rise it holds the full span
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            meas_cnt_q <= '0;
            period_q <= PW'(`CCGS_PERIOD_INIT);
        end else if (osc_rise) begin
            meas_cnt_q <= PW'(1);
            period_q <= meas_cnt_q;
        end else if (meas_cnt_q != '1) begin
            meas_cnt_q <= meas_cnt_q + PW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            trans_cnt_q <= 3'h0;
        end else if (resync || trans_cnt_q >= resync_span) begin
            trans_cnt_q <= 3'h0;
        end else if (osc_edge) begin
            trans_cnt_q <= trans_cnt_q + 3'h1;
        end
    end

    // ---------------- pll model ----------------
    // estimate steps by one per resync so the frequency only jumps when the factor changes
    logic [PW-1:0] est_q;
    logic [PW-1:0] est_d;
    logic [PW-1:0] acc_q;
    logic [PW-1:0] acc_sum;
    logic pll_tick;
    logic locked;

    assign est_d = !resync ? est_q :
                   (period_q > est_q) ? est_q + PW'(1) :
                   (period_q < est_q && est_q > PW'(f_twice)) ? est_q - PW'(1) :
                   est_q;
    // phase accumulator: f_twice toggles per estimated input period
    assign acc_sum = acc_q + PW'(f_twice);
    assign pll_tick = acc_sum >= est_q;
    assign locked = est_q == period_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            est_q <= PW'(`CCGS_PERIOD_INIT);
        end else begin
            est_q <= est_d;
        end
    end

    // parked at zero outside pll modes so a later switch starts from a clean phase
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= '0;
        end else if (mode != CCGS_MODE_PLL) begin
            acc_q <= '0;
        end else if (pll_tick) begin
            acc_q <= acc_sum - est_q;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // ---------------- cpu clock output ----------------
    logic cpu_clk_d;

    always_comb begin
        case (mode)
            CCGS_MODE_DIRECT: cpu_clk_d = osc_in;
            CCGS_MODE_PRESCALE: cpu_clk_d = osc_rise ? !cpu_clk : cpu_clk;
            CCGS_MODE_PLL: cpu_clk_d = pll_tick ? !cpu_clk : cpu_clk;
            default: cpu_clk_d = cpu_clk;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cpu_clk <= 1'b0;
            clock_half_period <= 1'b0;
            pll_enable <= 1'b0;
        end else begin
            cpu_clk <= cpu_clk_d;
            clock_half_period <= cpu_clk_d != cpu_clk;
            pll_enable <= mode == CCGS_MODE_PLL;
        end
    end

    // ---------------- AXI4-Lite slave ----------------
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_ok;

    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_ctrl = do_write && aw_addr_q == `CCGS_OFF_RST_CTRL;
    assign wr_cmd = do_write && aw_addr_q == `CCGS_OFF_CMD;
    assign wr_ok = wr_ctrl || wr_cmd || (aw_addr_q == `CCGS_OFF_CFG_LATCH)
                   || (aw_addr_q == `CCGS_OFF_STATUS) || (aw_addr_q == `CCGS_OFF_PERIOD);
    assign sw_load = wr_cmd && w_strb_q[0] && w_data_q[`CCGS_CMD_LOAD_BIT];
    // byte lanes of the control register follow their own write strobes
    for (genvar b = 0; b < 2; b++) begin : g_ctrl_lane
        assign rst_ctrl_d[8*b +: 8] = (wr_ctrl && w_strb_q[b]) ? w_data_q[8*b +: 8]
            : rst_ctrl_q[8*b +: 8];
    end

    logic b_done;

    assign b_done = s_axi_bvalid && s_axi_bready;

    // readies drop the cycle after a handshake and stay low while an item is held
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (b_done) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
        end else if (b_done) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (b_done) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read side
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] status_word;

    assign rd_addr = {s_axi_araddr[7:2], 2'h0};
    assign status_word = {est_q, 11'h000, locked, pll_enable, clock_mode_field};
    assign rd_ok = (rd_addr == `CCGS_OFF_CFG_LATCH) || (rd_addr == `CCGS_OFF_RST_CTRL)
                   || (rd_addr == `CCGS_OFF_CMD) || (rd_addr == `CCGS_OFF_STATUS)
                   || (rd_addr == `CCGS_OFF_PERIOD);
    assign rd_data = (rd_addr == `CCGS_OFF_CFG_LATCH) ? {24'h000000, cfg_latch_q} :
                     (rd_addr == `CCGS_OFF_RST_CTRL) ? {16'h0000, rst_ctrl_q} :
                     (rd_addr == `CCGS_OFF_STATUS) ? status_word :
                     (rd_addr == `CCGS_OFF_PERIOD) ? {16'h0000, period_q} :
                     32'h00000000;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // ccgs_top

// File: verif/ccgs_chk.sv
// port checker for the cpu clock generator
// assumes it is bound to ccgs_top and that core_clk is its only clock
`timescale 1ns/1ps
module ccgs_chk (
    // clock, reset and pins
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic osc_in,
    input wire logic [7:0] config_port_upper_byte,
    input wire logic long_hw_reset,
    input wire logic cpu_clk,
    input wire logic clock_half_period,
    input wire logic pll_enable,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire logic [2:0] pin_mode = config_port_upper_byte[7:5];
    // four capture cycles leave room for the latch and the mode register
    sequence hold_mode(logic [2:0] m);
        (long_hw_reset && pin_mode == m)[*4];
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    half_unit_a: assert property (clock_half_period == $changed(cpu_clk))
        else $error("strobe not tied to cpu clock edge");
    pll_on_a: assert property (hold_mode(3'h7) |-> pll_enable)
        else $error("pll not enabled");
    direct_a:
        assert property (hold_mode(3'h3) |-> !pll_enable && cpu_clk == $past(osc_in))
        else $error("direct drive not following oscillator");
    presc_tog_a: assert property (hold_mode(3'h1) ##0 $rose(osc_in) |=> $changed(cpu_clk))
        else $error("prescaler missed a rise");
    presc_hold_a:
        assert property (hold_mode(3'h1) ##0 !$rose(osc_in) |=> $stable(cpu_clk))
        else $error("prescaler phase cut short");
    wr_resp_a: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read data dropped");
endmodule // ccgs_chk

bind ccgs_top ccgs_chk u_chk (.*);

// File: verif/ccgs_osc.sv
// oscillator stand-in with programmable high and low spans
// assumes spans in core_clk cycles, level changes just after a rising edge
`timescale 1ns/1ps
module ccgs_osc (
    // clock
    input wire logic core_clk,
    // spans
    input wire logic [7:0] hi_cyc,
    input wire logic [7:0] lo_cyc,
    // oscillator level
    output logic osc_out
);
    logic [7:0] cnt_q;
    initial begin
        osc_out = 1'b0;
        cnt_q = 8'h00;
    end
    // uneven spans expose any duty-cycle dependence of the cpu clock
    always @(posedge core_clk) begin
        if (cnt_q + 8'h01 >= (osc_out ? hi_cyc : lo_cyc)) begin
            osc_out <= ~osc_out;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // ccgs_osc

// File: verif/ccgs_tb.sv
// self-checking bench for the cpu clock generator over AXI4-Lite
// assumes ccgs_osc as oscillator and the checker bound to ccgs_top
`timescale 1ns/1ps
module testbench;
    logic core_clk, nrst, osc_in, long_hw_reset, cpu_clk, clock_half_period, pll_enable;
    logic [7:0] config_port_upper_byte, hi_cyc, lo_cyc, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    int tf [6] = '{8, 6, 4, 10, 3, 5};
    int err_count, cmp_count, g1, g2, c;

    ccgs_top dut (.*);
    ccgs_osc osc (.core_clk(core_clk), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .osc_out(osc_in));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // no cycle limit in the bus tasks: only the watchdog ends a stuck transfer
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, wd, done;
        ad = 0;
        wd = 0;
        done = 0;
        r = 2'h3;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        d = 32'h0;
        r = 2'h3;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        axr(a, d, rs);
        chk(d, e);
        chk({30'h0, rs}, 32'h0);
    endtask

    // pulse spacing equals one cpu clock phase in core cycles
    task automatic gaps(output int a, output int b);
        int n;
        n = 0;
        a = 0;
        b = 0;
        do begin @(posedge core_clk); n++; end while (clock_half_period !== 1'b1 && n < 200);
        do begin @(posedge core_clk); a++; end while (clock_half_period !== 1'b1 && a < 200);
        do begin @(posedge core_clk); b++; end while (clock_half_period !== 1'b1 && b < 200);
    endtask

    task automatic hwcap(input logic [7:0] v);
        @(posedge core_clk);
        config_port_upper_byte <= v;
        long_hw_reset <= 1'b1;
        repeat (50) @(posedge core_clk);
        long_hw_reset <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        {nrst, long_hw_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        config_port_upper_byte = 8'hE3;
        hi_cyc = 8'h0F;
        lo_cyc = 8'h19;
        err_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdchk(8'h00, 32'hE3);
        chk(pll_enable, 1'b1);
        hwcap(8'h6A);
        rdchk(8'h00, 32'h6A);
        gaps(g1, g2);
        chk(g1 + g2, 40);
        chk(g1 == 15 || g1 == 25, 1'b1);
        chk(pll_enable, 1'b0);
        $display("direct drive test done");
        hwcap(8'h25);
        gaps(g1, g2);
        chk(g1, 40);
        chk(g2, 40);
        axw(8'h00, 32'h0, rs);
        chk({30'h0, rs}, 32'h0);
        rdchk(8'h00, 32'h25);
        $display("prescaler test done");
        hi_cyc <= 8'h14;
        lo_cyc <= 8'h14;
        // the span change stretches one high phase to 20 cycles; the rise spacing and the estimate stay at 40
        repeat (400) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            axw(8'h04, {16'h0, codes[i], 13'h0}, rs);
            axw(8'h08, 32'h1, rs);
            rdchk(8'h00, {24'h0, codes[i], 5'h0});
            repeat (200) @(posedge core_clk);
            chk(pll_enable, 1'b1);
            pulses(400, c);
            chk(c >= 10 * tf[i] - 1 && c <= 10 * tf[i] + 1, 1'b1);
            rdchk(8'h0C, {16'h0028, 11'h0, 2'h3, codes[i]});
        end
        $display("pll factor test done");
        rdchk(8'h10, 32'h28);
        rdchk(8'h08, 32'h0);
        axw(8'h20, 32'h1, rs);
        chk({30'h0, rs}, 32'h2);
        axr(8'h20, rdv, rs);
        chk(rdv, 32'h0);
        chk({30'h0, rs}, 32'h2);
        hwcap(8'hE3);
        rdchk(8'h00, 32'hE3);
        chk(pll_enable, 1'b1);
        $display("register map test done");
        tally_and_finish();
    end

    task automatic pulses(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            if (clock_half_period === 1'b1) n++;
        end
    endtask
endmodule // testbench
